// File: hw/ssq_pkg.sv
package ssq_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int T_ACCESS_NS = 70;
	localparam int CYC_ACCESS = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_POWERUP_NS = 500;
	localparam int CYC_POWERUP = (T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 2;

	localparam logic [20:0] ADDR_UNLOCK1 = 21'h00_0555;
	localparam logic [20:0] ADDR_UNLOCK2 = 21'h00_02AA;
	localparam logic [20:0] ADDR_QUERY = 21'h00_0055;
	localparam logic [20:0] ADDR_ZERO = 21'h00_0000;
	localparam logic [15:0] DATA_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
	localparam logic [15:0] CMD_SEC_ENTER = 16'h0088;
	localparam logic [15:0] CMD_SEC_EXIT = 16'h0090;
	localparam logic [15:0] CMD_SEC_EXIT2 = 16'h0000;
	localparam logic [15:0] CMD_QUERY = 16'h0098;
	localparam logic [15:0] CMD_RESET = 16'h00F0;

	// Secured sector window in word addresses, top-boot layout.
	localparam logic [20:0] SEC_BASE = 21'h1F_F000;
	localparam logic [20:0] SEC_LAST = 21'h1F_F07F;

	localparam logic [20:0] QRY_FIRST = 21'h00_0010;
	localparam logic [3:0] QRY_LAST_IDX = 4'hA;
	localparam logic [15:0] QRY_W10 = 16'h0051;
	localparam logic [15:0] QRY_W11 = 16'h0052;
	localparam logic [15:0] QRY_W12 = 16'h0059;
	localparam logic [15:0] QRY_W13 = 16'h0002;
	localparam logic [15:0] QRY_W15 = 16'h0040;
	localparam logic [15:0] QRY_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_READ = 3'h1,
		OP_WRITE = 3'h2,
		OP_SEC_ENTER = 3'h3,
		OP_SEC_EXIT = 3'h4,
		OP_QRY_ENTER = 3'h5,
		OP_RESET = 3'h6,
		OP_QRY_CHECK = 3'h7
	} ssq_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ISSUE = 2'h1,
		ST_WAIT = 2'h3,
		ST_POWER = 2'h2
	} ssq_state_t;

	typedef struct packed {
		logic last;
		logic wr;
		logic [20:0] addr;
		logic [15:0] data;
	} ssq_step_t;

endpackage : ssq_pkg

// File: hw/ssq_bus_cycle.sv
module ssq_bus_cycle (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Cycle request
	input wire logic start_i,
	input wire logic wr_i,
	input wire logic [21:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic done_o,
	// Flash pins
	output logic ce_n_o,
	output logic we_n_o,
	output logic oe_n_o,
	output logic [21:0] addr_o,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic dq_oe_n_o
);

	localparam logic [3:0] PULSE_W = 4'(ssq_pkg::CYC_ACCESS);
	localparam logic [3:0] PULSE_R = 4'(ssq_pkg::CYC_ACCESS + ssq_pkg::SYNC_STAGES);

	logic [1:0] phase_reg;
	logic [3:0] cnt_reg;
	logic wr_reg;
	logic [15:0] dq_s1_reg;
	logic [15:0] dq_s2_reg;
	wire pulse_end = (cnt_reg == (wr_reg ? PULSE_W : PULSE_R));

	// Read data comes from outside the clock domain.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dq_s1_reg <= 16'h0000;
			dq_s2_reg <= 16'h0000;
		end else begin
			dq_s1_reg <= dq_i;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	// Phases: 0 idle, 1 setup, 2 strobe, 3 hold.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_reg <= 2'h0;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
			ce_n_o <= 1'b1;
			we_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			addr_o <= 22'h00_0000;
			dq_o <= 16'h0000;
			dq_oe_n_o <= 1'b1;
			rdata_o <= 16'h0000;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (phase_reg)
				2'h0: begin
					if (start_i) begin
						phase_reg <= 2'h1;
						wr_reg <= wr_i;
						ce_n_o <= 1'b0;
						addr_o <= addr_i;
						dq_o <= wdata_i;
						dq_oe_n_o <= ~wr_i;
					end
				end
				2'h1: begin
					phase_reg <= 2'h2;
					cnt_reg <= 4'h1;
					we_n_o <= ~wr_reg;
					oe_n_o <= wr_reg;
				end
				2'h2: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (pulse_end) begin
						phase_reg <= 2'h3;
						we_n_o <= 1'b1;
						oe_n_o <= 1'b1;
						if (!wr_reg) begin
							rdata_o <= dq_s2_reg;
						end
					end
				end
				default: begin
					phase_reg <= 2'h0;
					ce_n_o <= 1'b1;
					dq_oe_n_o <= 1'b1;
					done_o <= 1'b1;
				end
			endcase
		end
	end

endmodule : ssq_bus_cycle

// File: hw/ssq_host.sv
module ssq_host (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// User command port
	input wire logic req_i,
	input wire logic [2:0] op_i,
	input wire logic [20:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic byte_mode_i,
	output logic ready_o,
	output logic done_o,
	output logic err_o,
	output logic [15:0] rdata_o,
	output logic qry_ok_o,
	output logic sec_mode_o,
	output logic qry_mode_o,
	// Flash pins
	output logic flash_ce_n_o,
	output logic flash_we_n_o,
	output logic flash_oe_n_o,
	output logic flash_reset_n_o,
	output logic [21:0] flash_addr_o,
	input wire logic [15:0] flash_dq_i,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe_n_o,
	input wire logic flash_busy_n_i,
	input wire logic supply_ok_i
);

	function automatic ssq_pkg::ssq_step_t step_of(input logic [2:0] op, input logic [3:0] idx,
		input logic [20:0] ua, input logic [15:0] ud);
		ssq_pkg::ssq_step_t s;
		s = '{last: 1'b1, wr: 1'b0, addr: ua, data: ud};
		case (op)
			ssq_pkg::OP_WRITE: s.wr = 1'b1;
			ssq_pkg::OP_SEC_ENTER, ssq_pkg::OP_SEC_EXIT: begin
				s.wr = 1'b1;
				s.last = (op == ssq_pkg::OP_SEC_ENTER) ? (idx == 4'h2) : (idx == 4'h3);
				case (idx)
					4'h0: s.addr = ssq_pkg::ADDR_UNLOCK1;
					4'h1: s.addr = ssq_pkg::ADDR_UNLOCK2;
					4'h2: s.addr = ssq_pkg::ADDR_UNLOCK1;
					default: s.addr = ssq_pkg::ADDR_ZERO;
				endcase
				case (idx)
					4'h0: s.data = ssq_pkg::DATA_UNLOCK1;
					4'h1: s.data = ssq_pkg::DATA_UNLOCK2;
					4'h2: s.data = (op == ssq_pkg::OP_SEC_ENTER) ? ssq_pkg::CMD_SEC_ENTER : ssq_pkg::CMD_SEC_EXIT;
					default: s.data = ssq_pkg::CMD_SEC_EXIT2;
				endcase
			end
			ssq_pkg::OP_QRY_ENTER: begin
				s.wr = 1'b1;
				s.addr = ssq_pkg::ADDR_QUERY;
				s.data = ssq_pkg::CMD_QUERY;
			end
			ssq_pkg::OP_RESET: begin
				s.wr = 1'b1;
				s.addr = ssq_pkg::ADDR_ZERO;
				s.data = ssq_pkg::CMD_RESET;
			end
			ssq_pkg::OP_QRY_CHECK: begin
				s.addr = ssq_pkg::QRY_FIRST + {17'h0_0000, idx};
				s.last = (idx == ssq_pkg::QRY_LAST_IDX);
			end
			default: s.last = 1'b1;
		endcase
		return s;
	endfunction : step_of

	function automatic logic [15:0] qry_expect(input logic [3:0] idx);
		case (idx)
			4'h0: return ssq_pkg::QRY_W10;
			4'h1: return ssq_pkg::QRY_W11;
			4'h2: return ssq_pkg::QRY_W12;
			4'h3: return ssq_pkg::QRY_W13;
			4'h5: return ssq_pkg::QRY_W15;
			default: return ssq_pkg::QRY_ZERO;
		endcase
	endfunction : qry_expect

	ssq_pkg::ssq_state_t state_reg;
	logic [2:0] op_reg;
	logic [3:0] idx_reg;
	logic [20:0] uaddr_reg;
	logic [15:0] udata_reg;
	logic sec_mode_reg;
	logic qry_mode_reg;
	logic match_reg;
	logic [7:0] pwr_cnt_reg;
	logic start_reg;
	logic busy_s1_reg;
	logic busy_s2_reg;
	logic sup_s1_reg;
	logic sup_s2_reg;
	logic [15:0] bus_rdata;
	logic bus_done;

	// Both status pins are asynchronous to the clock.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_s1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
			sup_s1_reg <= 1'b0;
			sup_s2_reg <= 1'b0;
		end else begin
			busy_s1_reg <= ~flash_busy_n_i;
			busy_s2_reg <= busy_s1_reg;
			sup_s1_reg <= supply_ok_i;
			sup_s2_reg <= sup_s1_reg;
		end
	end

	wire in_sec_window = (addr_i >= ssq_pkg::SEC_BASE) && (addr_i <= ssq_pkg::SEC_LAST);
	wire array_op = (op_i == ssq_pkg::OP_READ) || (op_i == ssq_pkg::OP_WRITE);
	wire refuse_supply = ~sup_s2_reg;
	wire refuse_query = (op_i == ssq_pkg::OP_QRY_ENTER) && (busy_s2_reg || qry_mode_reg);
	wire refuse_sec = sec_mode_reg && array_op && !in_sec_window;
	wire refuse_qmode = qry_mode_reg && array_op;
	wire refuse_check = (op_i == ssq_pkg::OP_QRY_CHECK) && !qry_mode_reg;
	wire refuse = refuse_supply || refuse_query || refuse_sec || refuse_qmode || refuse_check;
	wire accept = (state_reg == ssq_pkg::ST_IDLE) && req_i && (op_i != ssq_pkg::OP_NONE);
	ssq_pkg::ssq_step_t cur_step;
	assign cur_step = step_of(op_reg, idx_reg, uaddr_reg, udata_reg);
	// Byte mode presents the doubled address; the low byte carries the data.
	wire [21:0] pin_addr = byte_mode_i ? {cur_step.addr, 1'b0} : {1'b0, cur_step.addr};
	wire [15:0] rd_cmp = byte_mode_i ? {8'h00, bus_rdata[7:0]} : bus_rdata;
	wire step_match = (rd_cmp == qry_expect(idx_reg));

	// Sequencer: power-up hold, then one bus cycle per step.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ssq_pkg::ST_POWER;
			pwr_cnt_reg <= 8'h00;
			flash_reset_n_o <= 1'b0;
			op_reg <= 3'h0;
			idx_reg <= 4'h0;
			uaddr_reg <= 21'h00_0000;
			udata_reg <= 16'h0000;
			start_reg <= 1'b0;
			ready_o <= 1'b0;
			done_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= 16'h0000;
			match_reg <= 1'b0;
			qry_ok_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			err_o <= 1'b0;
			start_reg <= 1'b0;
			case (state_reg)
				ssq_pkg::ST_POWER: begin
					// Pins stay idle with reset held, so no stray write is seen.
					pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
					if (pwr_cnt_reg == 8'(ssq_pkg::CYC_POWERUP)) begin
						flash_reset_n_o <= 1'b1;
						state_reg <= ssq_pkg::ST_IDLE;
						ready_o <= 1'b1;
					end
				end
				ssq_pkg::ST_IDLE: begin
					if (accept) begin
						ready_o <= 1'b0;
						if (refuse) begin
							err_o <= 1'b1;
							done_o <= 1'b1;
							ready_o <= 1'b1;
						end else begin
							op_reg <= op_i;
							idx_reg <= 4'h0;
							uaddr_reg <= addr_i;
							udata_reg <= wdata_i;
							match_reg <= 1'b1;
							state_reg <= ssq_pkg::ST_ISSUE;
						end
					end
				end
				ssq_pkg::ST_ISSUE: begin
					start_reg <= 1'b1;
					state_reg <= ssq_pkg::ST_WAIT;
				end
				ssq_pkg::ST_WAIT: begin
					if (bus_done) begin
						rdata_o <= bus_rdata;
						if (op_reg == ssq_pkg::OP_QRY_CHECK && !step_match) begin
							match_reg <= 1'b0;
						end
						if (cur_step.last) begin
							state_reg <= ssq_pkg::ST_IDLE;
							done_o <= 1'b1;
							ready_o <= 1'b1;
							if (op_reg == ssq_pkg::OP_QRY_CHECK) begin
								qry_ok_o <= match_reg && step_match;
							end
						end else begin
							idx_reg <= idx_reg + 4'h1;
							state_reg <= ssq_pkg::ST_ISSUE;
						end
					end
				end
				default: state_reg <= ssq_pkg::ST_IDLE;
			endcase
		end
	end

	// Mode tracking mirrors what the flash is doing after each finished sequence.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sec_mode_reg <= 1'b0;
			qry_mode_reg <= 1'b0;
		end else if (!sup_s2_reg) begin
			sec_mode_reg <= 1'b0;
			qry_mode_reg <= 1'b0;
		end else if (state_reg == ssq_pkg::ST_WAIT && bus_done && cur_step.last) begin
			if (op_reg == ssq_pkg::OP_SEC_ENTER) begin
				sec_mode_reg <= 1'b1;
			end else if (op_reg == ssq_pkg::OP_SEC_EXIT) begin
				sec_mode_reg <= 1'b0;
			end
			if (op_reg == ssq_pkg::OP_QRY_ENTER) begin
				qry_mode_reg <= 1'b1;
			end else if (op_reg == ssq_pkg::OP_RESET) begin
				qry_mode_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sec_mode_o <= 1'b0;
			qry_mode_o <= 1'b0;
		end else begin
			sec_mode_o <= sec_mode_reg;
			qry_mode_o <= qry_mode_reg;
		end
	end

	ssq_bus_cycle u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(start_reg),
		.wr_i(cur_step.wr),
		.addr_i(pin_addr),
		.wdata_i(cur_step.data),
		.rdata_o(bus_rdata),
		.done_o(bus_done),
		.ce_n_o(flash_ce_n_o),
		.we_n_o(flash_we_n_o),
		.oe_n_o(flash_oe_n_o),
		.addr_o(flash_addr_o),
		.dq_i(flash_dq_i),
		.dq_o(flash_dq_o),
		.dq_oe_n_o(flash_dq_oe_n_o)
	);

endmodule : ssq_host

// File: verification/ssq_host_props.sv
module ssq_host_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Observed ports
	input wire logic byte_mode_i,
	input wire logic supply_ok_i,
	input wire logic err_o,
	input wire logic sec_mode_o,
	input wire logic qry_mode_o,
	input wire logic flash_ce_n_o,
	input wire logic flash_we_n_o,
	input wire logic flash_oe_n_o,
	input wire logic [21:0] flash_addr_o,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] last_wr_reg;
	logic [20:0] word;
	assign word = byte_mode_i ? flash_addr_o[21:1] : flash_addr_o[20:0];
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) last_wr_reg <= 16'h0000;
		else if (!flash_we_n_o) last_wr_reg <= flash_dq_o;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_write_pins;
		!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && !flash_dq_oe_n_o;
	endproperty
	a_write_pins: assert property (p_write_pins) else $error("write strobe with bad pins");
	property p_read_pins;
		!flash_oe_n_o |-> flash_we_n_o && flash_dq_oe_n_o && !flash_ce_n_o;
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("read strobe with bad pins");
	property p_we_width;
		$fell(flash_we_n_o) |-> !flash_we_n_o[*7] ##1 flash_we_n_o;
	endproperty
	a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
	property p_oe_width;
		$fell(flash_oe_n_o) |-> !flash_oe_n_o[*8] ##1 !flash_oe_n_o ##1 flash_oe_n_o;
	endproperty
	a_oe_width: assert property (p_oe_width) else $error("read strobe width wrong");
	property p_sec_window;
		!flash_oe_n_o && sec_mode_o && !qry_mode_o |-> word[20:7] == 14'h3FE0;
	endproperty
	a_sec_window: assert property (p_sec_window) else $error("read outside window in secure mode");
	property p_query_addr;
		!flash_we_n_o && flash_dq_o[7:0] == 8'h98 |-> word == 21'h00_0055;
	endproperty
	a_query_addr: assert property (p_query_addr) else $error("query command at wrong address");
	property p_qry_rose;
		$rose(qry_mode_o) |-> last_wr_reg[7:0] == 8'h98;
	endproperty
	a_qry_rose: assert property (p_qry_rose) else $error("query mode without query command");
	property p_qry_fell;
		$fell(qry_mode_o) && supply_ok_i && $past(supply_ok_i, 4) |-> last_wr_reg[7:0] == 8'hF0;
	endproperty
	a_qry_fell: assert property (p_qry_fell) else $error("query mode left without reset command");
	property p_sec_rose;
		$rose(sec_mode_o) |-> last_wr_reg[7:0] == 8'h88;
	endproperty
	a_sec_rose: assert property (p_sec_rose) else $error("secure mode without enter sequence");
	property p_sec_fell;
		$fell(sec_mode_o) && supply_ok_i && $past(supply_ok_i, 4) |-> last_wr_reg[7:0] == 8'h00;
	endproperty
	a_sec_fell: assert property (p_sec_fell) else $error("secure mode left without exit sequence");
	c_qry: cover property ($rose(qry_mode_o));
	c_sec: cover property ($rose(sec_mode_o));
	c_err: cover property (err_o);
endmodule : ssq_host_props

bind ssq_host ssq_host_props u_ssq_host_props (.clk_i, .rst_i, .byte_mode_i, .supply_ok_i, .err_o, .sec_mode_o,
	.qry_mode_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_n_o);

// File: verification/ssq_flash_model.sv
module ssq_flash_model (
	// Control pins
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic reset_n_i,
	input wire logic byte_i,
	input wire logic busy_n_i,
	input wire logic supply_ok_i,
	// Address and data
	input wire logic [21:0] addr_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// No high-voltage reset and no accelerate pin reach this model, so temporary unprotect and
	// accelerated programming of the secured sector can never be started from the host.
	logic sec_reg = 1'b0;
	logic qry_reg = 1'b0;
	logic [1:0] step_reg = 2'h0;
	logic [20:0] word;
	logic [15:0] q;
	logic [15:0] rd;
	logic [7:0] d;
	assign word = byte_i ? addr_i[21:1] : addr_i[20:0];
	assign d = dq_i[7:0];
	always @(posedge we_n_i or negedge reset_n_i or negedge supply_ok_i) begin
		if (!reset_n_i || !supply_ok_i) begin
			sec_reg = 1'b0;
			qry_reg = 1'b0;
			step_reg = 2'h0;
		end else if (!ce_n_i && oe_n_i) begin
			// Data written into the locked window is dropped, so its read pattern never changes.
			if (d == 8'hF0) qry_reg = 1'b0;
			else if (d == 8'h98 && word == 21'h55 && busy_n_i) qry_reg = 1'b1;
			else if (step_reg == 2'h0 && d == 8'hAA && word == 21'h555) step_reg = 2'h1;
			else if (step_reg == 2'h1 && d == 8'h55 && word == 21'h2AA) step_reg = 2'h2;
			else if (step_reg == 2'h2 && d == 8'h88) sec_reg = 1'b1;
			else if (step_reg == 2'h2 && d == 8'h90) step_reg = 2'h3;
			else if (step_reg == 2'h3 && d == 8'h00) sec_reg = 1'b0;
			if (d != 8'hAA && d != 8'h55 && d != 8'h90) step_reg = 2'h0;
		end
	end
	always_comb begin
		case (word)
			21'h10: q = 16'h0051;
			21'h11: q = 16'h0052;
			21'h12: q = 16'h0059;
			21'h13: q = 16'h0002;
			21'h15: q = 16'h0040;
			default: q = 16'h0000;
		endcase
	end
	// In query mode, byte mode puts a junk upper byte out so that a host using it is caught.
	assign rd = qry_reg ? (byte_i ? {8'hA5, q[7:0]} : q) :
		(sec_reg && word[20:7] == 14'h3FE0) ? (16'h5EC0 ^ word[15:0]) : word[15:0];
	assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
endmodule : ssq_flash_model

// File: verification/ssq_host_tb.sv
module ssq_host_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_i = 1'b0;
	logic byte_mode_i = 1'b0;
	logic flash_busy_n_i = 1'b1;
	logic supply_ok_i = 1'b1;
	logic [2:0] op_i = 3'h0;
	logic [20:0] addr_i = 21'h00_0000;
	logic [15:0] wdata_i = 16'h0000;
	logic ready_o, done_o, err_o, qry_ok_o, sec_mode_o, qry_mode_o;
	logic flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_reset_n_o, flash_dq_oe_n_o;
	logic [15:0] rdata_o, flash_dq_o, flash_dq_i, dq_m;
	logic [21:0] flash_addr_o;
	int fails = 0;
	int n_compared = 0;
	assign flash_dq_i = !flash_dq_oe_n_o ? flash_dq_o : dq_m;
	ssq_host u_ssq_host (.clk_i, .rst_i, .req_i, .op_i, .addr_i, .wdata_i, .byte_mode_i, .ready_o, .done_o,
		.err_o, .rdata_o, .qry_ok_o, .sec_mode_o, .qry_mode_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o,
		.flash_reset_n_o, .flash_addr_o, .flash_dq_i, .flash_dq_o, .flash_dq_oe_n_o, .flash_busy_n_i, .supply_ok_i);
	ssq_flash_model u_ssq_flash_model (.ce_n_i(flash_ce_n_o), .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o),
		.reset_n_i(flash_reset_n_o), .byte_i(byte_mode_i), .busy_n_i(flash_busy_n_i), .supply_ok_i(supply_ok_i),
		.addr_i(flash_addr_o), .dq_i(flash_dq_i), .dq_o(dq_m));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick
	// Every wait is bounded so that a stuck handshake ends the run.
	task automatic wait_for(input logic want_done);
		int n = 0;
		while ((want_done ? done_o : ready_o) !== 1'b1) begin
			tick();
			n++;
			if (n > 2000) begin
				fails++;
				print_verdict();
			end
		end
	endtask : wait_for
	task automatic do_op(input logic [2:0] op, input logic [20:0] a, input logic e);
		wait_for(1'b0);
		req_i = 1'b1;
		op_i = op;
		addr_i = a;
		tick();
		req_i = 1'b0;
		op_i = 3'h0;
		wait_for(1'b1);
		chk("err_o", 16'(err_o), 16'(e));
		tick();
	endtask : do_op
	task automatic t_query(input logic bm);
		byte_mode_i = bm;
		do_op(3'h7, 21'h00_0000, 1'b1);
		do_op(3'h5, 21'h00_0000, 1'b0);
		chk("qry_mode_o", 16'(qry_mode_o), 16'h0001);
		do_op(3'h5, 21'h00_0000, 1'b1);
		do_op(3'h7, 21'h00_0000, 1'b0);
		chk("qry_ok_o", 16'(qry_ok_o), 16'h0001);
		do_op(3'h1, 21'h00_0010, 1'b1);
		do_op(3'h6, 21'h00_0000, 1'b0);
		chk("qry_mode_o", 16'(qry_mode_o), 16'h0000);
	endtask : t_query
	task automatic t_busy();
		flash_busy_n_i = 1'b0;
		repeat (4) tick();
		do_op(3'h5, 21'h00_0000, 1'b1);
		chk("qry_mode_o", 16'(qry_mode_o), 16'h0000);
		flash_busy_n_i = 1'b1;
		repeat (4) tick();
	endtask : t_busy
	task automatic t_sec();
		do_op(3'h3, 21'h00_0000, 1'b0);
		chk("sec_mode_o", 16'(sec_mode_o), 16'h0001);
		do_op(3'h1, 21'h1F_F003, 1'b0);
		chk("rdata_o", rdata_o, 16'h5EC0 ^ 16'hF003);
		wdata_i = 16'h1234;
		do_op(3'h2, 21'h00_0100, 1'b1);
		do_op(3'h2, 21'h1F_F003, 1'b0);
		do_op(3'h1, 21'h1F_F003, 1'b0);
		chk("rdata_o", rdata_o, 16'h5EC0 ^ 16'hF003);
		do_op(3'h1, 21'h00_0100, 1'b1);
		do_op(3'h4, 21'h00_0000, 1'b0);
		do_op(3'h1, 21'h1F_F003, 1'b0);
		chk("rdata_o", rdata_o, 16'hF003);
	endtask : t_sec
	task automatic t_supply();
		do_op(3'h3, 21'h00_0000, 1'b0);
		supply_ok_i = 1'b0;
		repeat (4) tick();
		chk("sec_mode_o", 16'(sec_mode_o), 16'h0000);
		do_op(3'h1, 21'h00_0100, 1'b1);
		supply_ok_i = 1'b1;
		repeat (4) tick();
		do_op(3'h1, 21'h1F_F003, 1'b0);
		chk("rdata_o", rdata_o, 16'hF003);
	endtask : t_supply
	task automatic t_reset();
		do_op(3'h3, 21'h00_0000, 1'b0);
		rst_i = 1'b1;
		repeat (2) tick();
		rst_i = 1'b0;
		chk("sec_mode_o", 16'(sec_mode_o), 16'h0000);
		repeat (ssq_pkg::CYC_POWERUP) tick();
		chk("flash_reset_n_o", 16'(flash_reset_n_o), 16'h0000);
		chk("ready_o", 16'(ready_o), 16'h0000);
		tick();
		chk("flash_reset_n_o", 16'(flash_reset_n_o), 16'h0001);
		chk("ready_o", 16'(ready_o), 16'h0001);
		do_op(3'h1, 21'h1F_F003, 1'b0);
		chk("rdata_o", rdata_o, 16'hF003);
	endtask : t_reset
	initial begin
		repeat (16) tick();
		rst_i = 1'b0;
		t_query(1'b0);
		t_query(1'b1);
		byte_mode_i = 1'b0;
		t_busy();
		t_sec();
		t_supply();
		t_reset();
		print_verdict();
	end
endmodule : ssq_host_tb
